// ===== core/icap_timer_capture.sv
// timer pair with 16/32-bit chaining and a four-deep input capture channel, wishbone slave
// Notes on behaviour
// - chain bit set: pair counts as one 32-bit timer; clear: two 16-bit timers
// - while chained, every high control bit is ignored; low control governs
// - run bit starts and stops counting; governs whole pair when chained
// - timer idle-stop set halts timer in idle; clear keeps it running
// - gate accumulation applies only with internal clock; ignored with external clock
// - prescale 00,01,10,11 divide input clock by 1,8,64,256
// - clock source set counts external pin rising edges, else instruction clock
// - unimplemented control bits read as zero
// - a qualifying capture pin event records the selected timer's 16-bit count
// - time base select 1 captures first timer, 0 captures second timer
// - mode 001 every edge, 010 falling edges, 011 rising edges
// - mode 100 every 4th rising edge, 101 every 16th rising edge
// - mode 000 turns capture off; 110 is unused and disabled
// - mode 111 only gives rising-edge interrupt in sleep or idle
// - interrupt after every 1st, 2nd, 3rd or 4th capture per field
// - every-edge mode interrupts on each capture regardless of that field
// - captured values sit in a four-word first-in first-out buffer
// - overflow flag is read-only, set on overflow, cleared by hardware only
// - not-empty flag reads 1 while unread values remain
// - capture idle-stop set halts capture channel in idle
// - a capture pin edge can wake the device from sleep and idle
// - when chained, high count holds upper word, low count lower word
// - count equal to period resets to zero and resumes
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "icap_consts.svh"
module icap_timer_capture #(
  parameter int FIFO_DEPTH = 4,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // wishbone slave
  input wire icap_pkg::icap_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic capture_pin_i,
  input wire logic timer_external_clock_pin_i,
  input wire logic high_timer_external_clock_pin_i,
  input wire logic low_gate_pin_i,
  input wire logic high_gate_pin_i,
  // device power state
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  // events
  output logic capture_irq_o,
  output logic wake_o,
  output logic high_period_match_o
);
  localparam int PTR_W = $clog2(FIFO_DEPTH);

  // pin synchronisers: second stage feeds logic, third stage keeps last value for edges
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
    end else begin
      sync1 <= {high_gate_pin_i, low_gate_pin_i, high_timer_external_clock_pin_i,
                timer_external_clock_pin_i, capture_pin_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic cap_rise;
  logic cap_fall;
  assign cap_rise = sync2[0] & ~sync3[0];
  assign cap_fall = ~sync2[0] & sync3[0];

  // registers
  logic [15:0] lo_ctrl;
  logic [15:0] hi_ctrl;
  logic [15:0] cap_ctrl;
  logic [15:0] lo_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] lo_per;
  logic [15:0] hi_per;

  function automatic icap_pkg::icap_tmr_cfg_t cfg_of(input logic [15:0] c);
    icap_pkg::icap_tmr_cfg_t r;
    r.run = c[`ICAP_TMR_RUN];
    r.idle_stop = c[`ICAP_TMR_IDLE_STOP];
    r.gate = c[`ICAP_TMR_GATE];
    r.prescale = c[`ICAP_TMR_PS_HI:`ICAP_TMR_PS_LO];
    r.chain = c[`ICAP_TMR_CHAIN];
    r.clk_src = c[`ICAP_TMR_CLK_SRC];
    return r;
  endfunction : cfg_of

  function automatic logic [15:0] ps_limit(input logic [1:0] ps);
    case (ps)
      2'b01: ps_limit = `ICAP_PS_DIV_8;
      2'b10: ps_limit = `ICAP_PS_DIV_64;
      2'b11: ps_limit = `ICAP_PS_DIV_256;
      default: ps_limit = 16'h0000;
    endcase
  endfunction : ps_limit

  icap_pkg::icap_tmr_cfg_t cfg_lo;
  icap_pkg::icap_tmr_cfg_t cfg_hi;
  logic chained;
  assign cfg_lo = cfg_of(lo_ctrl);
  assign chained = cfg_lo.chain;
  assign cfg_hi = chained ? cfg_lo : cfg_of(hi_ctrl);

  // per-timer tick: source, gate, idle-stop and prescaler
  logic [1:0] src_evt;
  logic [1:0] tick;
  logic [15:0] ps_cnt [2];
  icap_pkg::icap_tmr_cfg_t cfg_v [2];
  assign cfg_v[0] = cfg_lo;
  assign cfg_v[1] = cfg_hi;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      logic ext_rise;
      logic gate_lvl;
      logic live;
      // chained pair takes the low timer's clock and gate
      assign ext_rise = (chained ? (sync2[1] & ~sync3[1])
                                 : (sync2[1 + g] & ~sync3[1 + g]));
      assign gate_lvl = chained ? sync2[3] : sync2[3 + g];
      assign live = cfg_v[g].run & ~(cfg_v[g].idle_stop & cpu_idle_i);
      always_comb begin
        if (!live) begin
          src_evt[g] = 1'b0;
        end else if (cfg_v[g].clk_src) begin
          src_evt[g] = ext_rise;
        end else begin
          src_evt[g] = ~cfg_v[g].gate | gate_lvl;
        end
      end
      assign tick[g] = src_evt[g] & (ps_cnt[g] >= ps_limit(cfg_v[g].prescale));
      always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ps_cnt[g] <= 16'h0000;
        end else if (!live) begin
          ps_cnt[g] <= 16'h0000;
        end else if (tick[g]) begin
          ps_cnt[g] <= 16'h0000;
        end else if (src_evt[g]) begin
          ps_cnt[g] <= ps_cnt[g] + 16'h0001;
        end
      end
    end
  endgenerate

  // bus decode
  logic bus_hit;
  logic wr_en;
  logic rd_en;
  logic [7:0] adr;
  assign bus_hit = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr_en = bus_hit & wb_req_i.we;
  assign rd_en = bus_hit & ~wb_req_i.we;
  assign adr = wb_req_i.adr[7:0];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // counters
  logic lo_match;
  logic hi_match;
  logic wide_match;
  assign lo_match = lo_cnt == lo_per;
  assign hi_match = hi_cnt == hi_per;
  assign wide_match = lo_match & hi_match;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
    end else begin
      if (chained) begin
        if (tick[0]) begin
          if (wide_match) begin
            lo_cnt <= 16'h0000;
            hi_cnt <= 16'h0000;
          end else begin
            {hi_cnt, lo_cnt} <= {hi_cnt, lo_cnt} + 32'h0000_0001;
          end
        end
      end else begin
        if (tick[0]) begin
          lo_cnt <= lo_match ? 16'h0000 : lo_cnt + 16'h0001;
        end
        if (tick[1]) begin
          hi_cnt <= hi_match ? 16'h0000 : hi_cnt + 16'h0001;
        end
      end
      if (wr_en && adr == `ICAP_ADR_LO_CNT) begin
        lo_cnt <= merge(lo_cnt, wb_req_i.dat, wb_req_i.sel);
      end
      if (wr_en && adr == `ICAP_ADR_HI_CNT) begin
        hi_cnt <= merge(hi_cnt, wb_req_i.dat, wb_req_i.sel);
      end
    end
  end
  assign high_period_match_o = chained ? (tick[0] & wide_match) : (tick[1] & hi_match);

  // control and period registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_ctrl <= `ICAP_CTRL_RESET;
      hi_ctrl <= `ICAP_CTRL_RESET;
      lo_per <= `ICAP_PER_RESET;
      hi_per <= `ICAP_PER_RESET;
    end else if (wr_en) begin
      case (adr)
        `ICAP_ADR_LO_CTRL: lo_ctrl <= merge(lo_ctrl, wb_req_i.dat, wb_req_i.sel)
                                      & `ICAP_LO_CTRL_MASK;
        `ICAP_ADR_HI_CTRL: hi_ctrl <= merge(hi_ctrl, wb_req_i.dat, wb_req_i.sel)
                                      & `ICAP_HI_CTRL_MASK;
        `ICAP_ADR_LO_PER: lo_per <= merge(lo_per, wb_req_i.dat, wb_req_i.sel);
        `ICAP_ADR_HI_PER: hi_per <= merge(hi_per, wb_req_i.dat, wb_req_i.sel);
        default: ;
      endcase
    end
  end

  // capture channel
  icap_pkg::icap_mode_t mode;
  logic cap_live;
  logic [3:0] edge_cnt;
  logic pin_evt;
  logic cap_evt;
  logic [15:0] cap_val;
  assign mode = icap_pkg::icap_mode_t'(cap_ctrl[2:0]);
  assign cap_live = ~(cap_ctrl[`ICAP_CAP_IDLE_STOP] & cpu_idle_i);
  assign cap_val = cap_ctrl[`ICAP_CAP_TB_SEL] ? lo_cnt : hi_cnt;

  always_comb begin
    case (mode)
      icap_pkg::ICAP_ANY: pin_evt = cap_rise | cap_fall;
      icap_pkg::ICAP_FALL: pin_evt = cap_fall;
      icap_pkg::ICAP_RISE: pin_evt = cap_rise;
      icap_pkg::ICAP_RISE4: pin_evt = cap_rise & (edge_cnt[1:0] == 2'b11);
      icap_pkg::ICAP_RISE16: pin_evt = cap_rise & (edge_cnt == 4'hF);
      default: pin_evt = 1'b0;
    endcase
  end
  assign cap_evt = pin_evt & cap_live;

  // prescaled edge counter restarts on every mode write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      edge_cnt <= 4'h0;
    end else if (wr_en && adr == `ICAP_ADR_CAP_CTRL) begin
      edge_cnt <= 4'h0;
    end else if (cap_live && cap_rise) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  // four-word buffer
  logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] fill;
  logic ovf;
  logic fifo_full;
  logic fifo_pop;
  logic fifo_push;
  assign fifo_full = fill == (PTR_W+1)'(FIFO_DEPTH);
  assign fifo_pop = rd_en && adr == `ICAP_ADR_CAP_BUF && fill != '0;
  assign fifo_push = cap_evt & ~fifo_full;
  always_ff @(posedge clk_sys_i) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr] <= cap_val[DATA_W-1:0];
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else if (mode == icap_pkg::ICAP_OFF) begin
      wr_ptr <= '0; // turning the channel off flushes the buffer
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (fifo_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fill <= fill + (PTR_W+1)'(fifo_push) - (PTR_W+1)'(fifo_pop);
    end
  end
  // overflow: set wins over the clear by emptying
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf <= 1'b0;
    end else if (cap_evt && fifo_full) begin
      ovf <= 1'b1;
    end else if (fill == '0 || mode == icap_pkg::ICAP_OFF) begin
      ovf <= 1'b0;
    end
  end

  // interrupt after the selected number of captures
  logic [1:0] cap_seen;
  logic cpi_hit;
  assign cpi_hit = (mode == icap_pkg::ICAP_ANY)
                   || (cap_seen == cap_ctrl[`ICAP_CAP_CPI_HI:`ICAP_CAP_CPI_LO]);
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_seen <= 2'b00;
    end else if (wr_en && adr == `ICAP_ADR_CAP_CTRL) begin
      cap_seen <= 2'b00;
    end else if (fifo_push) begin
      cap_seen <= cpi_hit ? 2'b00 : cap_seen + 2'b01;
    end
  end
  logic asleep;
  logic wake_evt;
  assign asleep = cpu_sleep_i | cpu_idle_i;
  assign wake_evt = (mode == icap_pkg::ICAP_WAKE) & asleep & cap_rise;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      capture_irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      capture_irq_o <= (fifo_push & cpi_hit) | wake_evt;
      wake_o <= asleep & ((fifo_push & cpi_hit) | wake_evt);
    end
  end

  // capture control: status bits are not writable
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_ctrl <= `ICAP_CTRL_RESET;
    end else if (wr_en && adr == `ICAP_ADR_CAP_CTRL) begin
      cap_ctrl <= merge(cap_ctrl, wb_req_i.dat, wb_req_i.sel) & `ICAP_CAP_WR_MASK;
    end
  end

  // read data and ack; registered ack adds one wait state, ack pulses for one cycle
  logic [15:0] next_rd;
  always_comb begin
    next_rd = 16'h0000;
    case (adr)
      `ICAP_ADR_LO_CTRL: next_rd = lo_ctrl;
      `ICAP_ADR_HI_CTRL: next_rd = hi_ctrl;
      `ICAP_ADR_CAP_CTRL: next_rd = cap_ctrl | {11'h000, ovf, (fill != '0), 3'b000};
      `ICAP_ADR_LO_CNT: next_rd = lo_cnt;
      `ICAP_ADR_HI_CNT: next_rd = hi_cnt;
      `ICAP_ADR_LO_PER: next_rd = lo_per;
      `ICAP_ADR_HI_PER: next_rd = hi_per;
      `ICAP_ADR_CAP_BUF: next_rd = (fill != '0) ? fifo_mem[rd_ptr] : 16'h0000;
      default: next_rd = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_hit;
      if (rd_en) begin
        wb_dat_o <= {16'h0000, next_rd};
      end
    end
  end
endmodule : icap_timer_capture
`default_nettype wire

// ===== core/icap_consts.svh
// register offsets, field positions, reset values and prescale ratios of the capture block
`ifndef ICAP_CONSTS_SVH
`define ICAP_CONSTS_SVH
`define ICAP_ADR_LO_CTRL 8'h00
`define ICAP_ADR_HI_CTRL 8'h04
`define ICAP_ADR_CAP_CTRL 8'h08
`define ICAP_ADR_LO_CNT 8'h0C
`define ICAP_ADR_HI_CNT 8'h10
`define ICAP_ADR_LO_PER 8'h14
`define ICAP_ADR_HI_PER 8'h18
`define ICAP_ADR_CAP_BUF 8'h1C
`define ICAP_TMR_RUN 15
`define ICAP_TMR_IDLE_STOP 13
`define ICAP_TMR_GATE 6
`define ICAP_TMR_PS_HI 5
`define ICAP_TMR_PS_LO 4
`define ICAP_TMR_CHAIN 3
`define ICAP_TMR_CLK_SRC 1
`define ICAP_LO_CTRL_MASK 16'hA07A
`define ICAP_HI_CTRL_MASK 16'hA072
`define ICAP_CAP_IDLE_STOP 13
`define ICAP_CAP_TB_SEL 7
`define ICAP_CAP_CPI_HI 6
`define ICAP_CAP_CPI_LO 5
`define ICAP_CAP_OVF 4
`define ICAP_CAP_BNE 3
`define ICAP_CAP_WR_MASK 16'h20E7
`define ICAP_CTRL_RESET 16'h0000
`define ICAP_PER_RESET 16'hFFFF
`define ICAP_PS_DIV_8 16'h0007
`define ICAP_PS_DIV_64 16'h003F
`define ICAP_PS_DIV_256 16'h00FF
`endif

// ===== core/icap_pkg.sv
// types shared by the capture block
`default_nettype none
package icap_pkg;
  typedef enum logic [2:0] {
    ICAP_OFF = 3'b000, ICAP_ANY = 3'b001, ICAP_FALL = 3'b010, ICAP_RISE = 3'b011,
    ICAP_RISE4 = 3'b100, ICAP_RISE16 = 3'b101, ICAP_UNUSED = 3'b110, ICAP_WAKE = 3'b111
  } icap_mode_t;
  typedef struct packed {
    logic run;
    logic idle_stop;
    logic gate;
    logic [1:0] prescale;
    logic chain;
    logic clk_src;
  } icap_tmr_cfg_t;
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } icap_wb_req_t;
endpackage : icap_pkg
`default_nettype wire

// ===== tb/icap_timer_capture_monitor.sv
// port checker for the timer pair and capture block
`timescale 1ns/100ps
`default_nettype none
module icap_timer_capture_monitor #(
  parameter int FIFO_DEPTH = 4,
  parameter int DATA_W = 16
) (
  // clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire icap_pkg::icap_wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // power state and events
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  input wire logic capture_irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_take;
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_take ##0 (!wb_req_i.we && wb_req_i.adr[7:0] == a);
  endsequence
  a_ack_follows: assert property (s_take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_caused: assert property (wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  a_lo_ctrl_zero: assert property (
    s_rd(8'h00) |=> (wb_dat_o & ~32'h0000A07A) == 32'h0) else $error("low control unused bits");
  a_hi_ctrl_zero: assert property (
    s_rd(8'h04) |=> (wb_dat_o & ~32'h0000A072) == 32'h0) else $error("high control unused bits");
  a_cap_ctrl_zero: assert property (
    s_rd(8'h08) |=> (wb_dat_o & ~32'h000020FF) == 32'h0) else $error("capture control unused bits");
  a_dat_steady: assert property (!$stable(wb_dat_o) |-> wb_ack_o && !$past(wb_req_i.we))
    else $error("read data moved outside a read");
  a_irq_pulse: assert property (capture_irq_o |=> !capture_irq_o)
    else $error("interrupt longer than one cycle");
  a_wake_lowpower: assert property (wake_o |-> $past(cpu_idle_i || cpu_sleep_i))
    else $error("wake outside sleep or idle");
endmodule : icap_timer_capture_monitor
bind icap_timer_capture icap_timer_capture_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .DATA_W(DATA_W))
  u_icap_timer_capture_monitor (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_req_i(wb_req_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i),
  .capture_irq_o(capture_irq_o), .wake_o(wake_o));
`default_nettype wire

// ===== tb/icap_pin_source.sv
// far-side model: capture pin pulses and external timer clocks
`timescale 1ns/100ps
`default_nettype none
module icap_pin_source (
  // clock
  input wire logic clk_sys_i,
  // pins
  output logic capture_pin_o,
  output logic ext_lo_o,
  output logic ext_hi_o
);
  logic ext_run = 1'b0;
  logic [2:0] div = 3'h0;
  initial begin
    capture_pin_o = 1'b0;
    ext_lo_o = 1'b0;
    ext_hi_o = 1'b0;
  end
  // external clocks stand still until enabled, then one rising edge each 8 cycles
  always @(posedge clk_sys_i) begin
    div <= div + 3'h1;
    ext_lo_o <= ext_run & div[2];
    ext_hi_o <= ext_run & div[2];
  end
  // levels last 3 cycles, above the 1-cycle minimum of the pin synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      capture_pin_o <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      capture_pin_o <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
    end
  endtask : pulse
endmodule : icap_pin_source
`default_nettype wire

// ===== tb/test_icap_timer_capture.sv
// self-checking bench for the timer pair and capture block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_icap_timer_capture;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  icap_pkg::icap_wb_req_t req = '0;
  logic [31:0] dat;
  logic [31:0] q;
  logic ack, cap_pin, ext_lo, ext_hi, irq, wake, pm;
  logic gate = 1'b0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  int fail_count = 0;
  int compares = 0;
  int irq_n = 0;
  int wake_n = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    irq_n <= irq_n + int'(irq === 1'b1);
    wake_n <= wake_n + int'(wake === 1'b1);
  end
  icap_timer_capture u_icap_timer_capture (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack), .capture_pin_i(cap_pin),
    .timer_external_clock_pin_i(ext_lo), .high_timer_external_clock_pin_i(ext_hi),
    .low_gate_pin_i(gate), .high_gate_pin_i(gate), .cpu_idle_i(idle), .cpu_sleep_i(sleep),
    .capture_irq_o(irq), .wake_o(wake), .high_period_match_o(pm));
  icap_pin_source u_icap_pin_source (.clk_sys_i(clk_sys_i), .capture_pin_o(cap_pin),
    .ext_lo_o(ext_lo), .ext_hi_o(ext_hi));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    req <= '{adr: {24'h0, a}, dat: {16'h0, d}, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat;
    `CHK("ack", 1'b1, ack)
    if (ack !== 1'b1)
      report_and_stop();
    req <= '0;
    @(posedge clk_sys_i);
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0);
    `CHK($sformatf("reg %h", a), {16'h0, e}, q)
  endtask : rchk
  task automatic drain(output int c);
    c = 0;
    repeat (5) begin
      wb(1'b0, 8'h08, 16'h0);
      if (q[3] === 1'b1) begin
        wb(1'b0, 8'h1C, 16'h0);
        c++;
      end
    end
  endtask : drain
  task automatic iv_chk(input int e);
    int n, t;
    n = 0;
    t = 0;
    while (pm !== 1'b1 && n < 3000) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK("first match", 1'b1, pm)
    if (pm !== 1'b1)
      report_and_stop();
    do begin
      @(negedge clk_sys_i);
      t++;
    end while (pm !== 1'b1 && t < 3000);
    `CHK("interval", e, t)
    if (t >= 3000)
      report_and_stop();
  endtask : iv_chk
  task automatic none_chk();
    int c;
    c = 0;
    repeat (600) begin
      @(negedge clk_sys_i);
      c += int'(pm === 1'b1);
    end
    `CHK("matches", 0, c)
  endtask : none_chk
  task automatic t_regs();
    rchk(8'h18, 16'hFFFF);
    rchk(8'h00, 16'h0000);
    wb(1'b1, 8'h00, 16'hFFFF);
    rchk(8'h00, 16'hA07A);
    wb(1'b1, 8'h04, 16'hFFFF);
    rchk(8'h04, 16'hA072);
    wb(1'b1, 8'h08, 16'hFFFF);
    rchk(8'h08, 16'h20E7);
    wb(1'b1, 8'h20, 16'hFFFF);
    rchk(8'h20, 16'h0000);
    for (int i = 0; i < 3; i++)
      wb(1'b1, 8'(4 * i), 16'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_fifo();
    wb(1'b1, 8'h08, 16'h0083);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h0C, 16'h1100 + 16'(i));
      u_icap_pin_source.pulse(1);
    end
    rchk(8'h08, 16'h009B);
    for (int i = 0; i < 4; i++)
      rchk(8'h1C, 16'h1100 + 16'(i));
    rchk(8'h08, 16'h0083);
    wb(1'b1, 8'h08, 16'h0003);
    wb(1'b1, 8'h10, 16'h5A5A);
    u_icap_pin_source.pulse(1);
    rchk(8'h1C, 16'h5A5A);
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_modes();
    int m[7] = '{1, 2, 3, 4, 5, 0, 6};
    int p[7] = '{2, 3, 3, 8, 16, 3, 3};
    int e[7] = '{4, 3, 3, 2, 1, 0, 0};
    int c;
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, 8'h08, 16'(m[i]));
      u_icap_pin_source.pulse(p[i]);
      drain(c);
      `CHK("captures", e[i], c)
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_irq();
    int k[5] = '{3, 3, 3, 3, 1};
    int s[5] = '{0, 1, 2, 3, 3};
    int p[5] = '{4, 4, 4, 4, 2};
    int e[5] = '{4, 2, 1, 1, 4};
    int b, c;
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h08, 16'(s[i] * 32 + k[i]));
      b = irq_n;
      u_icap_pin_source.pulse(p[i]);
      repeat (4) @(posedge clk_sys_i);
      `CHK("irqs", e[i], irq_n - b)
      drain(c);
    end
    $display("test irq done");
  endtask : t_irq
  task automatic t_wake();
    int b, c;
    wb(1'b1, 8'h08, 16'h0007);
    for (int i = 0; i < 3; i++) begin
      idle <= (i == 0);
      sleep <= (i == 2);
      b = wake_n;
      u_icap_pin_source.pulse(1);
      repeat (3) @(posedge clk_sys_i);
      `CHK("wakes", (i == 1) ? 0 : 1, wake_n - b)
    end
    rchk(8'h08, 16'h0007);
    idle <= 1'b1;
    sleep <= 1'b0;
    wb(1'b1, 8'h08, 16'h2003);
    u_icap_pin_source.pulse(1);
    rchk(8'h08, 16'h2003);
    wb(1'b1, 8'h08, 16'h0003);
    u_icap_pin_source.pulse(1);
    rchk(8'h08, 16'h000B);
    drain(c);
    idle <= 1'b0;
    $display("test wake done");
  endtask : t_wake
  task automatic t_timer();
    int d[4] = '{1, 8, 64, 256};
    int n;
    // the capture tests left a large value in the high count; start it below its period
    wb(1'b1, 8'h10, 16'h0000);
    wb(1'b1, 8'h18, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h04, 16'h8000 | 16'(i << 4));
      iv_chk(2 * d[i]);
    end
    u_icap_pin_source.ext_run <= 1'b1;
    wb(1'b1, 8'h04, 16'h8002);
    iv_chk(16);
    wb(1'b1, 8'h04, 16'h8042);
    iv_chk(16);
    wb(1'b1, 8'h04, 16'h8040);
    none_chk();
    gate <= 1'b1;
    idle <= 1'b1;
    iv_chk(2);
    wb(1'b1, 8'h04, 16'hA000);
    none_chk();
    idle <= 1'b0;
    wb(1'b1, 8'h04, 16'h0030);
    none_chk();
    // clear both words first so the 32-bit count starts below the 32-bit period
    for (int i = 0; i < 4; i++)
      wb(1'b1, 8'h0C + 8'(4 * i), (i == 2) ? 16'h0001 : 16'h0000);
    wb(1'b1, 8'h00, 16'h8008);
    iv_chk(2);
    wb(1'b1, 8'h00, 16'h0008);
    none_chk();
    for (int i = 0; i < 4; i++)
      wb(1'b1, 8'h0C + 8'(4 * i), 16'(i == 0 ? 16'hFFF0 : (i == 3 ? 2 : 1)));
    wb(1'b1, 8'h00, 16'h8008);
    n = 0;
    while (pm !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK("carry", 1'b1, pm)
    $display("test timer done");
  endtask : t_timer
  initial begin
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_fifo();
    t_modes();
    t_irq();
    t_wake();
    t_timer();
    report_and_stop();
  end
endmodule : test_icap_timer_capture
`default_nettype wire
